/* hw/twm_timer.sv */
// Waveform generator of a 16-bit timer with an APB register slave.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps

module twm_timer
  import twm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_tick,
  input  wire logic        capture_event,
  output logic             pin_a_out,
  output logic             pin_a_oe,
  output logic             pin_b_out,
  output logic             pin_b_oe
);

  // ****************************************
  // APB decode
  // ****************************************
  logic [7:0]  ctrl;
  logic [15:0] counter_value;
  logic [15:0] capture_value;
  logic [15:0] cmp_buf [2];
  logic [15:0] cmp_act [2];
  logic [3:0]  flags;
  logic [3:0]  port_reg;
  logic [1:0]  latch;
  logic [1:0]  next_latch;
  logic [31:0] rd_mux;

  wire setup  = psel && !penable;
  wire wr     = psel && penable && pwrite;
  wire s_ctrl = paddr == TWM_OFF_CTRL;
  wire s_frc  = paddr == TWM_OFF_FORCE;
  wire s_cnt  = paddr == TWM_OFF_COUNT;
  wire s_cmpa = paddr == TWM_OFF_CMPA;
  wire s_cmpb = paddr == TWM_OFF_CMPB;
  wire s_capt = paddr == TWM_OFF_CAPT;
  wire s_flg  = paddr == TWM_OFF_FLAGS;
  wire s_port = paddr == TWM_OFF_PORT;
  wire hit    = s_ctrl | s_frc | s_cnt | s_cmpa | s_cmpb | s_capt | s_flg | s_port;

  // Zero wait states; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Read data is captured in the setup cycle so it comes from a flop.
  always_comb begin
    rd_mux = 32'h00000000;
    if (s_ctrl) rd_mux = {24'h000000, ctrl};
    if (s_cnt)  rd_mux = {16'h0000, counter_value};
    if (s_cmpa) rd_mux = {16'h0000, cmp_buf[0]};
    if (s_cmpb) rd_mux = {16'h0000, cmp_buf[1]};
    if (s_capt) rd_mux = {16'h0000, capture_value};
    if (s_flg)  rd_mux = {28'h0000000, flags};
    if (s_port) rd_mux = {28'h0000000, port_reg};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (setup) prdata <= rd_mux;
  end

  // ****************************************
  // Mode decode and top selection
  // ****************************************
  wire [3:0] mode  = ctrl[TWM_MODE_LSB +: 4];
  wire [1:0] com [2];
  assign com[0] = ctrl[TWM_COMA_LSB +: 2];
  assign com[1] = ctrl[TWM_COMB_LSB +: 2];

  // Counting depends only on the waveform mode, never on the output fields.
  wire fast = (mode == TWM_MODE_FAST8) || (mode == TWM_MODE_FAST9) ||
              (mode == TWM_MODE_FAST10) || (mode == TWM_MODE_FAST_CAPT) ||
              (mode == TWM_MODE_FAST_A);
  wire clr_mode = (mode == TWM_MODE_CLR_A) || (mode == TWM_MODE_CLR_CAPT);
  wire capt_top = (mode == TWM_MODE_CLR_CAPT) || (mode == TWM_MODE_FAST_CAPT);
  wire a_top    = (mode == TWM_MODE_CLR_A) || (mode == TWM_MODE_FAST_A);

  // The capture register is compared as written, so a top below the count is missed.
  logic [15:0] top;
  always_comb begin
    case (mode)
      TWM_MODE_FAST8:  top = TWM_TOP_8;
      TWM_MODE_FAST9:  top = TWM_TOP_9;
      TWM_MODE_FAST10: top = TWM_TOP_10;
      TWM_MODE_CLR_CAPT,
      TWM_MODE_FAST_CAPT: top = capture_value;
      TWM_MODE_CLR_A,
      TWM_MODE_FAST_A: top = cmp_act[0];
      default:         top = TWM_MAX;
    endcase
  end

  wire at_top  = (fast || clr_mode) && (counter_value == top);
  wire wrap    = timer_tick && at_top;
  wire cnt_wr  = wr && s_cnt;
  wire [15:0] next_count = at_top ? TWM_BOTTOM : counter_value + 16'h0001;

  // ****************************************
  // Counter
  // ****************************************
  // Software writes win over a tick in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) counter_value <= TWM_RST_CNT;
    else if (cnt_wr) counter_value <= pwdata[15:0];
    else if (timer_tick) counter_value <= next_count;
  end

  // ****************************************
  // Control, port and capture registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= TWM_RST_CTRL;
      port_reg <= 4'h0;
    end else begin
      if (wr && s_ctrl) ctrl <= pwdata[7:0];
      if (wr && s_port) port_reg <= pwdata[3:0];
    end
  end

  // Capture events load the count only when the register is not the top.
  wire cap_load = capture_event && !capt_top;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) capture_value <= TWM_RST_CNT;
    else if (wr && s_capt) capture_value <= pwdata[15:0];
    else if (cap_load) capture_value <= counter_value;
  end

  // ****************************************
  // Flags (set wins over write-one-to-clear)
  // ****************************************
  logic [3:0] flag_set;
  wire  [1:0] match_ev;
  assign match_ev[0] = timer_tick && (counter_value == cmp_act[0]);
  assign match_ev[1] = timer_tick && (counter_value == cmp_act[1]);

  // In fast mode overflow marks top; otherwise only the wrap from maximum.
  always_comb begin
    flag_set = 4'h0;
    flag_set[TWM_FLG_OVF]  = fast ? wrap : (timer_tick && counter_value == TWM_MAX);
    flag_set[TWM_FLG_CMPA] = match_ev[0] || (a_top && wrap);
    flag_set[TWM_FLG_CMPB] = match_ev[1];
    flag_set[TWM_FLG_CAPT] = capt_top ? wrap : cap_load;
  end

  wire [3:0] flag_clr = (wr && s_flg) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags <= 4'h0;
    else flags <= (flags & ~flag_clr) | flag_set;
  end

  // ****************************************
  // Compare channels and output latches
  // ****************************************
  wire [1:0] force_strobe = (wr && s_frc && !fast) ? pwdata[1:0] : 2'h0;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire cmp_wr = wr && (i == 0 ? s_cmpa : s_cmpb);

    // PWM writes stay in the buffer until the counter reaches top.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmp_buf[i] <= TWM_RST_CNT;
        cmp_act[i] <= TWM_RST_CNT;
      end else begin
        if (cmp_wr) cmp_buf[i] <= pwdata[15:0];
        if (cmp_wr && !fast) cmp_act[i] <= pwdata[15:0];
        else if (fast && wrap) cmp_act[i] <= cmp_buf[i];
      end
    end

    // The current field is used at each event, so a change acts at the next match.
    always_comb begin
      next_latch[i] = latch[i];
      if (fast) begin
        // Bottom wins over a match at top, giving a steady level when compare equals top.
        case (com[i])
          TWM_COM_CLEAR: begin
            if (wrap) next_latch[i] = 1'b1;
            else if (match_ev[i]) next_latch[i] = 1'b0;
          end
          TWM_COM_SET: begin
            if (wrap) next_latch[i] = 1'b0;
            else if (match_ev[i]) next_latch[i] = 1'b1;
          end
          TWM_COM_TOGGLE: begin
            if (i == 0 && mode == TWM_MODE_FAST_A && match_ev[i])
              next_latch[i] = !latch[i];
          end
          default: next_latch[i] = latch[i];
        endcase
      end else if (match_ev[i] || force_strobe[i]) begin
        case (com[i])
          TWM_COM_TOGGLE: next_latch[i] = !latch[i];
          TWM_COM_CLEAR:  next_latch[i] = 1'b0;
          TWM_COM_SET:    next_latch[i] = 1'b1;
          default:        next_latch[i] = latch[i];
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) latch[i] <= 1'b0;
      else latch[i] <= next_latch[i];
    end
  end

  // ****************************************
  // Pin override
  // ****************************************
  // Direction always stays with the port bits; only the level is overridden.
  assign pin_a_out = (com[0] != TWM_COM_OFF) ? latch[0] : port_reg[0];
  assign pin_b_out = (com[1] != TWM_COM_OFF) ? latch[1] : port_reg[1];
  assign pin_a_oe  = port_reg[TWM_PORT_DIR];
  assign pin_b_oe  = port_reg[TWM_PORT_DIR + 1];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The latch is held at zero for as long as reset is asserted.
  reset_latch_a: assert property (disable iff (1'b0)
    !presetn |-> latch == TWM_RST_LAT) else $error("latch not cleared in reset");

  // Pin levels follow the latch only while an action is selected.
  override_a: assert property (
    pin_a_out == ((com[0] != TWM_COM_OFF) ? latch[0] : port_reg[0]))
    else $error("pin A override wrong");
  override_b_a: assert property (
    pin_b_out == ((com[1] != TWM_COM_OFF) ? latch[1] : port_reg[1]))
    else $error("pin B override wrong");
  // The override never takes the direction away from the port bits.
  pin_dir_a: assert property (
    pin_a_oe == port_reg[TWM_PORT_DIR] && pin_b_oe == port_reg[TWM_PORT_DIR + 1])
    else $error("pin direction not from port");

  // A zero field freezes its latch whatever the counter does.
  hold_latch_a: assert property ((com[0] == TWM_COM_OFF && !(wr && s_ctrl))
    |=> $stable(latch[0])) else $error("latch A moved with action off");
  hold_latch_b_a: assert property ((com[1] == TWM_COM_OFF && !(wr && s_ctrl))
    |=> $stable(latch[1])) else $error("latch B moved with action off");

  // A forced match moves the latch but leaves flags and count alone.
  force_noflag_a: assert property ((force_strobe[0] && !match_ev[0] && !wrap)
    |=> flags[TWM_FLG_CMPA] == $past(flags[TWM_FLG_CMPA]))
    else $error("force strobe set flag");
  force_set_a: assert property ((force_strobe[0] && com[0] == TWM_COM_SET)
    |=> latch[0]) else $error("forced set not applied");
  // Outside fast PWM toggle flips once per match or strobe, so the output halves the rate.
  match_toggle_a: assert property ((!fast && com[0] == TWM_COM_TOGGLE &&
    (match_ev[0] || force_strobe[0])) |=> latch[0] != $past(latch[0]))
    else $error("toggle action missed");

  // Normal mode only ever counts up and wraps from the maximum.
  normal_wrap_a: assert property ((mode == TWM_MODE_NORMAL && timer_tick &&
    counter_value == TWM_MAX && !cnt_wr && !(wr && s_ctrl))
    |=> counter_value == TWM_BOTTOM && flags[TWM_FLG_OVF])
    else $error("normal wrap or overflow wrong");
  normal_step_a: assert property ((mode == TWM_MODE_NORMAL && timer_tick &&
    !cnt_wr) |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("normal count step wrong");
  cnt_write_a: assert property (cnt_wr |=>
    counter_value == $past(pwdata[15:0])) else $error("counter write lost");
  // Outside fast PWM overflow can only come from the wrap at the maximum.
  ovf_max_only_a: assert property ((!fast && !flags[TWM_FLG_OVF] &&
    !(timer_tick && counter_value == TWM_MAX)) |=> !flags[TWM_FLG_OVF])
    else $error("overflow set away from wrap");

  match_clear_a: assert property ((clr_mode && wrap && !cnt_wr &&
    !(wr && s_ctrl)) |=> counter_value == TWM_BOTTOM && !flags[TWM_FLG_OVF] ||
        $past(counter_value == TWM_MAX) || $past(flags[TWM_FLG_OVF]))
    else $error("clear-on-match failed");
  // The top register raises its own flag whenever top is reached.
  top_flag_a: assert property ((a_top && wrap) |=> flags[TWM_FLG_CMPA])
    else $error("compare A flag missing at top");
  capt_flag_a: assert property ((capt_top && wrap) |=> flags[TWM_FLG_CAPT])
    else $error("capture flag missing at top");
  // Without buffering a compare write takes effect at once.
  direct_cmp_a: assert property ((!fast && wr && s_cmpa) |=>
    cmp_act[0] == $past(pwdata[15:0])) else $error("unbuffered compare not loaded");

  // Capture follows events unless the register is defining top.
  capt_load_a: assert property ((capture_event && !capt_top && !(wr && s_capt))
    |=> capture_value == $past(counter_value)) else $error("capture not loaded");
  capt_hold_a: assert property ((capt_top && !(wr && s_capt))
    |=> $stable(capture_value)) else $error("top capture register moved");

  fast_top_a: assert property ((fast && wrap && !cnt_wr && !(wr && s_ctrl))
    |=> counter_value == TWM_BOTTOM && flags[TWM_FLG_OVF])
    else $error("fast top handling wrong");
  fast_step_a: assert property ((fast && timer_tick && !at_top && !cnt_wr)
    |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("fast count step wrong");
  // Active compare values only change at top while PWM is running.
  fast_buffer_a: assert property ((fast && wrap && !(wr && s_ctrl))
    |=> cmp_act[0] == $past(cmp_buf[0])) else $error("buffer not loaded");
  fast_hold_a: assert property ((fast && !wrap) |=>
    $stable(cmp_act[0]) && $stable(cmp_act[1])) else $error("compare left buffer early");
  cmpa_flag_a: assert property (match_ev[0] |=> flags[TWM_FLG_CMPA])
    else $error("compare A flag missing");
  cmpb_flag_a: assert property (match_ev[1] |=> flags[TWM_FLG_CMPB])
    else $error("compare B flag missing");

  // Both PWM polarities, at the match and at bottom.
  fast_bottom_a: assert property ((fast && wrap && com[0] == TWM_COM_SET &&
    !(wr && s_ctrl)) |=> !latch[0] ##1 $stable(latch[0]) || match_ev[0] || wrap)
    else $error("inverting bottom clear wrong");
  fast_bottom_set_a: assert property ((fast && wrap && com[0] == TWM_COM_CLEAR)
    |=> latch[0]) else $error("non-inverting bottom set wrong");
  fast_match_clr_a: assert property ((fast && !wrap && match_ev[0] &&
    com[0] == TWM_COM_CLEAR) |=> !latch[0]) else $error("non-inverting match wrong");
  fast_match_set_a: assert property ((fast && !wrap && match_ev[0] &&
    com[0] == TWM_COM_SET) |=> latch[0]) else $error("inverting match wrong");

  // Nothing but a register write or a capture event may move the count, flags or latches between timer ticks.
  tick_gate_a: assert property ((!timer_tick && !cnt_wr) |=> $stable(counter_value))
    else $error("counter moved without tick");
  flag_gate_a: assert property ((!timer_tick && !capture_event && !(wr && s_flg))
    |=> $stable(flags)) else $error("flags moved without tick");
  latch_gate_a: assert property ((!timer_tick && force_strobe == 2'h0)
    |=> $stable(latch)) else $error("latch moved without tick");

  clr_toggle_c: cover property (clr_mode && com[0] == TWM_COM_TOGGLE && match_ev[0]);
  fast_wrap_c: cover property (fast && wrap);
  force_c: cover property (force_strobe != 2'h0);
  normal_ovf_c: cover property (mode == TWM_MODE_NORMAL && flag_set[TWM_FLG_OVF]);
  inv_match_c: cover property (fast && com[0] == TWM_COM_SET && match_ev[0]);

endmodule

/* pkg/twm_pkg.sv */
// Constants shared by the 16-bit timer waveform block.
package twm_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [7:0] TWM_OFF_CTRL  = 8'h00;
  localparam logic [7:0] TWM_OFF_FORCE = 8'h04;
  localparam logic [7:0] TWM_OFF_COUNT = 8'h08;
  localparam logic [7:0] TWM_OFF_CMPA  = 8'h0C;
  localparam logic [7:0] TWM_OFF_CMPB  = 8'h10;
  localparam logic [7:0] TWM_OFF_CAPT  = 8'h14;
  localparam logic [7:0] TWM_OFF_FLAGS = 8'h18;
  localparam logic [7:0] TWM_OFF_PORT  = 8'h1C;

  localparam int unsigned TWM_MODE_LSB  = 0;
  localparam int unsigned TWM_COMA_LSB  = 4;
  localparam int unsigned TWM_COMB_LSB  = 6;
  localparam int unsigned TWM_FLG_OVF   = 0;
  localparam int unsigned TWM_FLG_CMPA  = 1;
  localparam int unsigned TWM_FLG_CMPB  = 2;
  localparam int unsigned TWM_FLG_CAPT  = 3;
  localparam int unsigned TWM_PORT_DIR  = 2;

  // ****************************************
  // Waveform modes and output actions
  // ****************************************
  localparam logic [3:0] TWM_MODE_NORMAL    = 4'h0;
  localparam logic [3:0] TWM_MODE_CLR_A     = 4'h4;
  localparam logic [3:0] TWM_MODE_FAST8     = 4'h5;
  localparam logic [3:0] TWM_MODE_FAST9     = 4'h6;
  localparam logic [3:0] TWM_MODE_FAST10    = 4'h7;
  localparam logic [3:0] TWM_MODE_CLR_CAPT  = 4'hC;
  localparam logic [3:0] TWM_MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] TWM_MODE_FAST_A    = 4'hF;

  localparam logic [1:0] TWM_COM_OFF    = 2'h0;
  localparam logic [1:0] TWM_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TWM_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TWM_COM_SET    = 2'h3;

  // ****************************************
  // Counter values and reset values
  // ****************************************
  localparam logic [15:0] TWM_TOP_8    = 16'h00FF;
  localparam logic [15:0] TWM_TOP_9    = 16'h01FF;
  localparam logic [15:0] TWM_TOP_10   = 16'h03FF;
  localparam logic [15:0] TWM_MAX      = 16'hFFFF;
  localparam logic [15:0] TWM_BOTTOM   = 16'h0000;
  localparam logic [15:0] TWM_RST_CNT  = 16'h0000;
  localparam logic [7:0]  TWM_RST_CTRL = 8'h00;
  localparam logic [1:0]  TWM_RST_LAT  = 2'h0;

endpackage

/* bench/twm_load.sv */
// Behavioural model of the external load on one compare output pin.
`timescale 1ns/100ps
module twm_load (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      level
);
  // The load pulls an undriven pin low, so no stale level survives a release.
  assign level = pin_oe ? pin_out : 1'b0;
endmodule

/* bench/timer16_waveform_modes_tb.sv */
// Self-checking bench for the timer waveform block.
`timescale 1ns/100ps
module timer16_waveform_modes_tb
  import twm_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, tick_en, cap_ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, rd_e, pa_out, pa_oe, pb_out, pb_oe, lvl_a, lvl_b;
  int          error_cnt, num_checks;

  // ****************************************
  // Design, loads and clock
  // ****************************************
  twm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(tick_en), .capture_event(cap_ev), .pin_a_out(pa_out),
    .pin_a_oe(pa_oe), .pin_b_out(pb_out), .pin_b_oe(pb_oe));
  twm_load i_load_a (.pin_out(pa_out), .pin_oe(pa_oe), .level(lvl_a));
  twm_load i_load_b (.pin_out(pb_out), .pin_oe(pb_oe), .level(lvl_b));

  // Free-running 250 MHz clock.
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // ****************************************
  // Access and check tasks
  // ****************************************
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers counts as a mismatch.
    if (pready !== 1'b1) error_cnt++;
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_q);
  endtask

  task automatic pin(input string nm, input logic exp);
    chk(nm, {31'h0, exp}, {31'h0, lvl_a});
  endtask

  // Exactly n rising edges see the timer enable high.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      tick_en <= 1'b1;
    end
    @(posedge pclk);
    tick_en <= 1'b0;
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    error_cnt = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick_en = 1'b0;
    cap_ev = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl reset", TWM_OFF_CTRL, 32'h0);
    pin("pin released", 1'b0);
    wr(TWM_OFF_PORT, 32'h5);
    pin("port level", 1'b1);
    chk("pin b released", 32'h0, {31'h0, lvl_b});
    wr(TWM_OFF_CTRL, 32'h10);
    pin("latch after reset", 1'b0);
    wr(TWM_OFF_FORCE, 32'h1);
    pin("forced toggle", 1'b1);
    rd("force flags", TWM_OFF_FLAGS, 32'h0);
    rd("force count", TWM_OFF_COUNT, 32'h0);
    wr(TWM_OFF_CTRL, 32'h00);
    wr(TWM_OFF_FORCE, 32'h1);
    wr(TWM_OFF_CTRL, 32'h10);
    pin("field zero holds", 1'b1);
    $display("override test done");
    wr(TWM_OFF_COUNT, 32'hFFFE);
    tick(1);
    rd("count max", TWM_OFF_COUNT, 32'hFFFF);
    @(posedge pclk);
    cap_ev <= 1'b1;
    @(posedge pclk);
    cap_ev <= 1'b0;
    rd("capture", TWM_OFF_CAPT, 32'hFFFF);
    tick(1);
    rd("count wrap", TWM_OFF_COUNT, 32'h0);
    rd("overflow", TWM_OFF_FLAGS, 32'h9);
    $display("normal test done");
    wr(TWM_OFF_FLAGS, 32'hF);
    wr(TWM_OFF_CMPA, 32'h2);
    wr(TWM_OFF_CTRL, 32'h14);
    tick(3);
    rd("ctc clear", TWM_OFF_COUNT, 32'h0);
    rd("ctc flags", TWM_OFF_FLAGS, 32'h6);
    pin("ctc toggle", 1'b0);
    tick(3);
    pin("ctc toggle back", 1'b1);
    $display("clear on match test done");
    wr(TWM_OFF_FLAGS, 32'hF);
    wr(TWM_OFF_CTRL, 32'h25);
    wr(TWM_OFF_CMPA, 32'h10);
    tick(3);
    pin("old compare active", 1'b0);
    wr(TWM_OFF_COUNT, 32'hFE);
    tick(2);
    rd("pwm restart", TWM_OFF_COUNT, 32'h0);
    rd("pwm flags", TWM_OFF_FLAGS, 32'h7);
    pin("set at bottom", 1'b1);
    wr(TWM_OFF_FLAGS, 32'hF);
    tick(16);
    pin("before match", 1'b1);
    tick(1);
    pin("clear on match", 1'b0);
    rd("match flags", TWM_OFF_FLAGS, 32'h6);
    wr(TWM_OFF_CTRL, 32'h35);
    wr(TWM_OFF_COUNT, 32'hFE);
    tick(19);
    pin("inverted set", 1'b1);
    wr(TWM_OFF_CTRL, 32'h0F);
    wr(TWM_OFF_FLAGS, 32'hF);
    wr(TWM_OFF_COUNT, 32'h0F);
    tick(2);
    rd("top a restart", TWM_OFF_COUNT, 32'h0);
    rd("top a flags", TWM_OFF_FLAGS, 32'h3);
    wr(TWM_OFF_CAPT, 32'h7);
    wr(TWM_OFF_CTRL, 32'h0E);
    wr(TWM_OFF_FLAGS, 32'hF);
    wr(TWM_OFF_COUNT, 32'h6);
    tick(2);
    rd("top capt restart", TWM_OFF_COUNT, 32'h0);
    rd("top capt flags", TWM_OFF_FLAGS, 32'h9);
    $display("fast pwm test done");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", 32'h0, rd_q);
    chk("unmapped error", 32'h1, {31'h0, rd_e});
    $display("unmapped test done");
    stop_test();
  end
endmodule
